/* hw/ddr2_cmd_pkg.sv */
// constants, command and power-state types for the ddr2 command core
// assumes a 40 mhz core clock and an eight-bank part with a 14-bit address bus
package ddr2_cmd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int ROW_W = 13;
  localparam int ALL_BANKS_BIT = 10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int REFRESH_ROWS = 8192;
  // average refresh spacing, rounded down so the window is always met
  localparam int REFI_CYCLES = REFRESH_WINDOW_MS * 1000000 / REFRESH_ROWS / CLK_PERIOD_NS;
  localparam int DELAY_W = 6;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam logic [BA_W-1:0] BA_MR = 3'h0;
  localparam logic [BA_W-1:0] BA_EMR1 = 3'h1;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int MR_DLL_RST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int MR_PD_SLOW_BIT = 12;
  localparam int EMR_DLL_DIS_BIT = 0;
  localparam int EMR_AL_LSB = 3;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] MR_CL_RST = 3'h3;
  localparam logic [2:0] MR_WR_RST = 3'h1;
  localparam logic [2:0] EMR_AL_RST = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_DESL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_READ, CMD_WRITE, CMD_MRS, CMD_REF
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ON, PWR_PPD, PWR_APD, PWR_SREF
  } pwr_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_DESL;
    if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h0: c = CMD_MRS;
        3'h1: c = CMD_REF;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd

endpackage : ddr2_cmd_pkg

/* hw/ap_timer.sv */
// one-bank auto-precharge countdown
// assumes the loader gives a delay of at least one cycle
`timescale 1ns/100ps
`default_nettype none
module ap_timer #(
  parameter int CNT_W = ddr2_cmd_pkg::DELAY_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] delay_i,
  input wire logic cancel_i,
  // status
  output logic fire_o
);

  logic [CNT_W-1:0] cnt_ff;

  // a fresh load replaces any pending start; zero means idle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= delay_i;
    end else if (cancel_i) begin
      cnt_ff <= '0;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fire_o <= 1'b0;
    end else begin
      fire_o <= !load_i && !cancel_i && (cnt_ff == CNT_W'(1));
    end
  end

endmodule : ap_timer
`default_nettype wire

/* hw/ddr2_cmd_core.sv */
// command decode, bank state, auto-precharge, refresh and power-down core
// assumes command pins are sampled on clk_i and the controller keeps its own spacing
//
// How it works
// - write with a10 high precharges its bank after burst plus write recovery.
// - refresh encoding refreshes using internal row counter, ignoring address.
// - cke low with nop or deselect enters power-down.
// - idle banks give precharge power-down, open row active; input buffers off.
// - dll off in precharge and slow-exit active power-down, on in fast exit.
// - cke high with nop or deselect leaves power-down.
// - commands decode from cs, ras, cas, we; a10 selects all-bank or ap.
// - refresh with cke falling enters self refresh; cke high leaves it at the next clock edge.
// - bank bits select bank or mode register; bl4 bursts never interrupted.
`timescale 1ns/100ps
`default_nettype none
module ddr2_cmd_core #(
  parameter int BANKS = ddr2_cmd_pkg::BANKS,
  parameter int ADDR_W = ddr2_cmd_pkg::ADDR_W,
  parameter int ROW_W = ddr2_cmd_pkg::ROW_W,
  parameter int REFI_CYCLES = ddr2_cmd_pkg::REFI_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [ddr2_cmd_pkg::BA_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // bank state
  output logic [BANKS-1:0] bank_open_o,
  output logic [BANKS-1:0] ap_start_o,
  // access events
  output logic rd_start_o,
  output logic wr_start_o,
  output logic [ddr2_cmd_pkg::BA_W-1:0] burst_bank_o,
  output logic cmd_illegal_o,
  output logic dll_reset_o,
  // refresh
  output logic refresh_o,
  output logic [ROW_W-1:0] refresh_row_o,
  // power
  output logic pd_precharge_o,
  output logic pd_active_o,
  output logic self_refresh_o,
  output logic in_buf_en_o,
  output logic dll_on_o
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (BANKS != (1 << ddr2_cmd_pkg::BA_W)) begin : g_bank_chk
    $error("BANKS must match the bank address width");
  end
  if (ADDR_W <= ddr2_cmd_pkg::MR_PD_SLOW_BIT || REFI_CYCLES < 2) begin : g_addr_chk
    $error("address bus too narrow or refresh interval too short");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  localparam int DW = ddr2_cmd_pkg::DELAY_W;

  ddr2_cmd_pkg::cmd_t cmd;
  ddr2_cmd_pkg::pwr_t pwr_ff;
  ddr2_cmd_pkg::pwr_t nxt_pwr;
  logic cke_prev_ff;
  logic in_normal;
  logic nop_like;
  logic all_sel;
  logic any_open;
  logic bl4_busy;
  logic rw_cmd;
  logic rw_ok;
  logic ref_ok;
  logic mrs_ok;
  logic mr_bl8_ff;
  logic [2:0] mr_cl_ff;
  logic [2:0] mr_wr_ff;
  logic [2:0] mr_al_ff;
  logic mr_slow_ff;
  logic emr_dll_dis_ff;
  logic [2:0] burst_cnt_ff;
  logic [DW-1:0] bl_half;
  logic [DW-1:0] wr_ap_delay;
  logic [DW-1:0] rd_ap_delay;
  logic [BANKS-1:0] ap_load;
  logic [BANKS-1:0] pre_hit;
  logic [BANKS-1:0] ap_fire;
  logic [$clog2(REFI_CYCLES)-1:0] sref_cnt_ff;
  logic sref_tick;

  assign cmd = ddr2_cmd_pkg::decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  assign in_normal = (pwr_ff == ddr2_cmd_pkg::PWR_ON) && cke_prev_ff && cke_i;
  assign nop_like = (cmd == ddr2_cmd_pkg::CMD_NOP) || (cmd == ddr2_cmd_pkg::CMD_DESL);
  assign all_sel = addr_i[ddr2_cmd_pkg::ALL_BANKS_BIT];
  assign any_open = |bank_open_o;
  // bl4 bursts run to the end; bl8 follow-ups are the controller's concern
  assign bl4_busy = !mr_bl8_ff && (burst_cnt_ff != 3'h0);
  assign rw_cmd = (cmd == ddr2_cmd_pkg::CMD_READ) || (cmd == ddr2_cmd_pkg::CMD_WRITE);
  assign rw_ok = in_normal && rw_cmd && !bl4_busy && bank_open_o[ba_i];
  // refresh address comes from the internal counter only
  assign ref_ok = in_normal && (cmd == ddr2_cmd_pkg::CMD_REF) && !any_open;
  assign mrs_ok = in_normal && (cmd == ddr2_cmd_pkg::CMD_MRS) && !any_open;

  // ----------------------------------------------------------------
  // auto-precharge delays
  // ----------------------------------------------------------------
  assign bl_half = mr_bl8_ff ? DW'(4) : DW'(2);
  // wl = al + cl - 1 and wr = code + 1, so the ones cancel
  assign wr_ap_delay = DW'(mr_al_ff) + DW'(mr_cl_ff) + bl_half + DW'(mr_wr_ff);
  assign rd_ap_delay = DW'(mr_al_ff) + bl_half;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign pre_hit[b] = in_normal && (cmd == ddr2_cmd_pkg::CMD_PRE)
                        && (all_sel || (ba_i == ddr2_cmd_pkg::BA_W'(b)));
    assign ap_load[b] = rw_ok && all_sel && (ba_i == ddr2_cmd_pkg::BA_W'(b));
    ap_timer #(
      .CNT_W(DW)
    ) u_ap_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .load_i(ap_load[b]),
      .delay_i((cmd == ddr2_cmd_pkg::CMD_WRITE) ? wr_ap_delay : rd_ap_delay),
      .cancel_i(pre_hit[b]),
      .fire_o(ap_fire[b])
    );
  end

  assign ap_start_o = ap_fire;

  // ----------------------------------------------------------------
  // bank state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_open_o <= '0;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (in_normal && (cmd == ddr2_cmd_pkg::CMD_ACT)
            && (ba_i == ddr2_cmd_pkg::BA_W'(b))) begin
          bank_open_o[b] <= 1'b1;
        end else if (pre_hit[b] || ap_fire[b]) begin
          bank_open_o[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_cnt_ff <= 3'h0;
      rd_start_o <= 1'b0;
      wr_start_o <= 1'b0;
      burst_bank_o <= '0;
      cmd_illegal_o <= 1'b0;
    end else begin
      rd_start_o <= rw_ok && (cmd == ddr2_cmd_pkg::CMD_READ);
      wr_start_o <= rw_ok && (cmd == ddr2_cmd_pkg::CMD_WRITE);
      cmd_illegal_o <= in_normal && rw_cmd && !rw_ok;
      if (rw_ok) begin
        burst_cnt_ff <= bl_half[2:0] - 3'h1;
        burst_bank_o <= ba_i;
      end else if (burst_cnt_ff != 3'h0) begin
        burst_cnt_ff <= burst_cnt_ff - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mr_bl8_ff <= 1'b0;
      mr_cl_ff <= ddr2_cmd_pkg::MR_CL_RST;
      mr_wr_ff <= ddr2_cmd_pkg::MR_WR_RST;
      mr_slow_ff <= 1'b0;
      mr_al_ff <= ddr2_cmd_pkg::EMR_AL_RST;
      emr_dll_dis_ff <= 1'b0;
      dll_reset_o <= 1'b0;
    end else begin
      dll_reset_o <= mrs_ok && (ba_i == ddr2_cmd_pkg::BA_MR)
                     && addr_i[ddr2_cmd_pkg::MR_DLL_RST_BIT];
      if (mrs_ok && (ba_i == ddr2_cmd_pkg::BA_MR)) begin
        mr_bl8_ff <= addr_i[ddr2_cmd_pkg::MR_BL_LSB +: 3] == ddr2_cmd_pkg::BL_CODE_8;
        mr_cl_ff <= addr_i[ddr2_cmd_pkg::MR_CL_LSB +: 3];
        mr_wr_ff <= addr_i[ddr2_cmd_pkg::MR_WR_LSB +: 3];
        mr_slow_ff <= addr_i[ddr2_cmd_pkg::MR_PD_SLOW_BIT];
      end
      if (mrs_ok && (ba_i == ddr2_cmd_pkg::BA_EMR1)) begin
        mr_al_ff <= addr_i[ddr2_cmd_pkg::EMR_AL_LSB +: 3];
        emr_dll_dis_ff <= addr_i[ddr2_cmd_pkg::EMR_DLL_DIS_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      ddr2_cmd_pkg::PWR_ON: begin
        if (cke_prev_ff && !cke_i) begin
          if ((cmd == ddr2_cmd_pkg::CMD_REF) && !any_open) begin
            nxt_pwr = ddr2_cmd_pkg::PWR_SREF;
          end else if (nop_like) begin
            nxt_pwr = any_open ? ddr2_cmd_pkg::PWR_APD : ddr2_cmd_pkg::PWR_PPD;
          end
        end
      end
      ddr2_cmd_pkg::PWR_PPD, ddr2_cmd_pkg::PWR_APD: begin
        if (cke_i && nop_like) begin
          nxt_pwr = ddr2_cmd_pkg::PWR_ON;
        end
      end
      ddr2_cmd_pkg::PWR_SREF: begin
        // exit needs no settled command decode: cke alone ends it
        if (cke_i) begin
          nxt_pwr = ddr2_cmd_pkg::PWR_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_ff <= ddr2_cmd_pkg::PWR_ON;
      cke_prev_ff <= 1'b0;
      pd_precharge_o <= 1'b0;
      pd_active_o <= 1'b0;
      self_refresh_o <= 1'b0;
      in_buf_en_o <= 1'b1;
      dll_on_o <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      cke_prev_ff <= cke_i;
      pd_precharge_o <= nxt_pwr == ddr2_cmd_pkg::PWR_PPD;
      pd_active_o <= nxt_pwr == ddr2_cmd_pkg::PWR_APD;
      self_refresh_o <= nxt_pwr == ddr2_cmd_pkg::PWR_SREF;
      in_buf_en_o <= nxt_pwr == ddr2_cmd_pkg::PWR_ON;
      dll_on_o <= !emr_dll_dis_ff
                  && (nxt_pwr != ddr2_cmd_pkg::PWR_PPD)
                  && (nxt_pwr != ddr2_cmd_pkg::PWR_SREF)
                  && !((nxt_pwr == ddr2_cmd_pkg::PWR_APD) && mr_slow_ff);
    end
  end

  // ----------------------------------------------------------------
  // refresh
  // ----------------------------------------------------------------
  // self refresh paces itself at the average interval, keeping the 64 ms window
  assign sref_tick = (pwr_ff == ddr2_cmd_pkg::PWR_SREF)
                     && (sref_cnt_ff == ($clog2(REFI_CYCLES))'(REFI_CYCLES - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sref_cnt_ff <= '0;
    end else if ((pwr_ff != ddr2_cmd_pkg::PWR_SREF) || sref_tick) begin
      sref_cnt_ff <= '0;
    end else begin
      sref_cnt_ff <= sref_cnt_ff + ($clog2(REFI_CYCLES))'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refresh_o <= 1'b0;
      refresh_row_o <= '0;
    end else begin
      refresh_o <= ref_ok || sref_tick;
      if (ref_ok || sref_tick) begin
        refresh_row_o <= refresh_row_o + ROW_W'(1);
      end
    end
  end

endmodule : ddr2_cmd_core
`default_nettype wire

/* testbench/ddr2_cmd_core_sva.sv */
// assertions on the ddr2 command core ports
// bound to every ddr2_cmd_core; one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module ddr2_cmd_core_sva #(
  parameter int BANKS = ddr2_cmd_pkg::BANKS,
  parameter int ADDR_W = ddr2_cmd_pkg::ADDR_W,
  parameter int ROW_W = ddr2_cmd_pkg::ROW_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [ddr2_cmd_pkg::BA_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // watched outputs
  input wire logic [BANKS-1:0] bank_open_o,
  input wire logic rd_start_o,
  input wire logic cmd_illegal_o,
  input wire logic refresh_o,
  input wire logic [ROW_W-1:0] refresh_row_o,
  input wire logic pd_precharge_o,
  input wire logic pd_active_o,
  input wire logic self_refresh_o,
  input wire logic in_buf_en_o,
  input wire logic dll_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cke history starts low, as the core's does
  logic cke_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cke_ff <= 1'b0;
    else cke_ff <= cke_i;
  end
  wire logic [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire logic on = in_buf_en_o && cke_i && cke_ff;
  wire logic idle_cmd = cs_n_i || (cmd == 4'h7);
  wire logic pd = pd_precharge_o || pd_active_o;
  sequence pd_entry_s;
    cke_i && in_buf_en_o ##1 !cke_i && idle_cmd && in_buf_en_o;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pd_entry_a: assert property (pd_entry_s |=> pd)
    else $error("power-down not entered");
  pd_kind_a: assert property ($rose(pd) |-> pd_active_o == (bank_open_o != '0))
    else $error("wrong power-down kind");
  pd_buffers_a: assert property (pd |-> !in_buf_en_o)
    else $error("input buffers on in power-down");
  dll_off_a: assert property (pd_precharge_o || self_refresh_o |-> !dll_on_o)
    else $error("dll running in precharge power-down");
  pd_exit_a: assert property (pd && cke_i && idle_cmd |=> in_buf_en_o && !pd)
    else $error("power-down not left");
  sref_exit_a: assert property (self_refresh_o && cke_i |=> !self_refresh_o)
    else $error("self refresh not left");
  refresh_row_a: assert property (refresh_o |-> refresh_row_o == $past(refresh_row_o) + 1'b1)
    else $error("refresh row counter did not step");
  read_closed_a: assert property (on && cmd == 4'h5 && !bank_open_o[ba_i]
    |=> cmd_illegal_o && !rd_start_o)
    else $error("read to closed bank accepted");
  act_open_a: assert property (on && cmd == 4'h3 |=> bank_open_o[$past(ba_i)])
    else $error("activate did not open bank");
  pre_all_a: assert property (on && cmd == 4'h2 && addr_i[10] |=> bank_open_o == '0)
    else $error("precharge all left a bank open");
endmodule : ddr2_cmd_core_sva
bind ddr2_cmd_core ddr2_cmd_core_sva #(.BANKS(BANKS), .ADDR_W(ADDR_W), .ROW_W(ROW_W)) sva (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i),
  .bank_open_o(bank_open_o), .rd_start_o(rd_start_o), .cmd_illegal_o(cmd_illegal_o),
  .refresh_o(refresh_o), .refresh_row_o(refresh_row_o), .pd_precharge_o(pd_precharge_o),
  .pd_active_o(pd_active_o), .self_refresh_o(self_refresh_o), .in_buf_en_o(in_buf_en_o),
  .dll_on_o(dll_on_o));
`default_nettype wire

/* testbench/ddr2_ctrl_model.sv */
// memory-controller model driving the command bus
// pins change just after the falling edge; callers keep analog spacings
`timescale 1ns/100ps
`default_nettype none
module ddr2_ctrl_model (
  // clock
  input wire logic clk_i,
  // command pins
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o
);
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'h7;
    ba_o = 3'h0;
    addr_o = 14'h0000;
  end
  // one command for one cycle; back to back calls give 1-clock spacing
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                       input logic k);
    cke_o = k;
    cmd_o = c;
    ba_o = b;
    addr_o = a;
    @(negedge clk_i);
  endtask : issue
  // nop; unused address bits toggle so stale values never look valid
  task automatic idle(input logic k);
    issue(4'h7, ~ba_o, ~addr_o, k);
  endtask : idle
endmodule : ddr2_ctrl_model
`default_nettype wire

/* testbench/ddr2_cmd_core_bench.sv */
// self-checking bench for the ddr2 command core
// refresh interval shortened to 8 cycles; mode register starts at reset values
`timescale 1ns/100ps
`default_nettype none
module ddr2_cmd_core_bench;
  localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4, MRS = 4'h0, REF = 4'h1;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  wire logic cke;
  wire logic [3:0] cmd;
  wire logic [2:0] ba;
  wire logic [13:0] addr;
  logic [7:0] bank_open, ap_start;
  logic rd_start, wr_start, illegal, dll_rst, refr, ppd, apd, sref, ibuf, dll_on;
  logic [12:0] row;
  logic [2:0] bank;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  // one fixed frequency for the whole run: no clock change is ever made
  always #12.5 clk_i = ~clk_i;
  ddr2_ctrl_model ctl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(addr));
  ddr2_cmd_core #(.REFI_CYCLES(8)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr), .bank_open_o(bank_open),
    .ap_start_o(ap_start), .rd_start_o(rd_start), .wr_start_o(wr_start), .burst_bank_o(bank),
    .cmd_illegal_o(illegal), .dll_reset_o(dll_rst), .refresh_o(refr), .refresh_row_o(row),
    .pd_precharge_o(ppd), .pd_active_o(apd), .self_refresh_o(sref), .in_buf_en_o(ibuf),
    .dll_on_o(dll_on));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // hang guard, well above the fewer than one hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_ap(); // auto-precharge delay 6 with reset mode
    ctl.issue(ACT, 3'h3, 14'h0000, 1'b1);
    ctl.issue(WR, 3'h3, 14'h0400, 1'b1);
    chk({wr_start, bank}, {1'b1, 3'h3});
    repeat (5) ctl.idle(1'b1);
    chk(ap_start, 8'h00);
    ctl.idle(1'b1);
    chk(ap_start, 8'h08);
    ctl.idle(1'b1);
    chk(bank_open, 8'h00);
    ctl.issue(ACT, 3'h3, 14'h0000, 1'b1);
    chk(bank_open, 8'h08);
    ctl.issue(PRE, 3'h3, 14'h0000, 1'b1);
  endtask : t_write_ap
  task automatic t_banks();
    ctl.issue(RD, 3'h5, 14'h0000, 1'b1);
    chk({illegal, rd_start}, 2'b10);
    ctl.issue(ACT, 3'h1, 14'h0000, 1'b1);
    ctl.issue(ACT, 3'h2, 14'h0000, 1'b1);
    chk(bank_open, 8'h06);
    ctl.issue(PRE, 3'h1, 14'h0000, 1'b1);
    chk(bank_open, 8'h04);
    ctl.issue(PRE, 3'h1, 14'h0400, 1'b1);
    chk(bank_open, 8'h00);
  endtask : t_banks
  task automatic t_refresh();
    ctl.idle(1'b1);
    ctl.issue(REF, 3'h5, 14'h2AAA, 1'b1);
    chk({refr, row}, {1'b1, 13'h0001});
    ctl.issue(ACT, 3'h0, 14'h0000, 1'b1);
    ctl.issue(REF, 3'h0, 14'h0000, 1'b1);
    chk(refr, 1'b0);
    ctl.issue(PRE, 3'h0, 14'h0400, 1'b1);
  endtask : t_refresh
  task automatic t_pd(input logic act, input logic [3:0] exp);
    if (act) ctl.issue(ACT, 3'h0, 14'h0000, 1'b1);
    else ctl.idle(1'b1);
    ctl.idle(1'b0);
    chk({ppd, apd, ibuf, dll_on}, exp);
    ctl.idle(1'b0);
    ctl.idle(1'b1);
    chk({ppd, apd, ibuf}, 3'b001);
    ctl.issue(PRE, 3'h0, 14'h0400, 1'b1);
  endtask : t_pd
  task automatic t_mode();
    ctl.issue(MRS, 3'h2, 14'h0100, 1'b1);
    chk(dll_rst, 1'b0);
    ctl.issue(MRS, 3'h0, 14'h1332, 1'b1);
    chk(dll_rst, 1'b1);
    t_pd(1'b1, 4'b0100);
  endtask : t_mode
  task automatic t_self_refresh();
    int n;
    ctl.idle(1'b1);
    ctl.issue(REF, 3'h0, 14'h0000, 1'b0);
    chk({sref, dll_on, ibuf}, 3'b100);
    n = 0;
    while (refr !== 1'b1 && n < 20) begin
      ctl.idle(1'b0);
      n++;
    end
    n = 0;
    do begin
      ctl.idle(1'b0);
      n++;
    end while (refr !== 1'b1 && n < 20);
    chk(16'(n), 16'd8);
    ctl.idle(1'b1);
    chk({sref, ibuf}, 2'b01);
  endtask : t_self_refresh
  // bl4 read with auto-precharge; a read one clock later must be refused
  task automatic t_read();
    ctl.issue(ACT, 3'h6, 14'h0000, 1'b1);
    ctl.issue(RD, 3'h6, 14'h0400, 1'b1);
    chk({rd_start, bank}, {1'b1, 3'h6});
    ctl.issue(RD, 3'h6, 14'h0000, 1'b1);
    chk({illegal, rd_start}, 2'b10);
    ctl.issue(4'h8, 3'h0, 14'h0000, 1'b1);
    chk(ap_start, 8'h40);
    ctl.idle(1'b1);
    chk(bank_open, 8'h00);
  endtask : t_read
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    @(negedge clk_i);
    chk({ibuf, dll_on, ppd, apd, sref, bank_open}, 13'h1800);
    t_write_ap();
    t_banks();
    t_refresh();
    t_pd(1'b0, 4'b1000);
    t_pd(1'b1, 4'b0101);
    t_mode();
    t_self_refresh();
    t_read();
    report_and_stop();
  end
endmodule : ddr2_cmd_core_bench
`default_nettype wire
